// file: sar_adc_pkg.sv
// package for the successive-approximation converter control unit
// assumes a single 200 MHz system clock and an ahb-lite register bus
package sar_adc_pkg;

  // ************************************************************
  // register map (byte addresses, one aligned word each)
  // ************************************************************
  localparam logic [11:0] main_control_addr  = 12'h000;
  localparam logic [11:0] ref_port_addr      = 12'h004;
  localparam logic [11:0] timing_format_addr = 12'h008;
  localparam logic [11:0] result_low_addr    = 12'h00c;
  localparam logic [11:0] result_high_addr   = 12'h010;
  localparam logic [11:0] status_addr        = 12'h014;

  // ************************************************************
  // field positions and reset values
  // ************************************************************
  localparam int calibrate_bit    = 7;
  localparam int chan_lsb         = 2;
  localparam int go_busy_bit      = 1;
  localparam int on_bit           = 0;
  localparam int neg_ref_bit      = 5;
  localparam int pos_ref_bit      = 4;
  localparam int justify_bit      = 7;
  localparam int acq_lsb          = 3;
  localparam logic [7:0] control_reset = 8'h00;
  localparam logic [3:0] last_channel  = 4'hb;
  localparam logic [3:0] all_analog_top = 4'h3;

  // ************************************************************
  // timing constants
  // ************************************************************
  localparam int clock_mhz         = 200;
  localparam int conv_periods      = 11;
  localparam int result_bits       = 10;
  localparam int instr_cycle_ns    = 20;
  localparam int instr_cycle_clks  = (instr_cycle_ns * clock_mhz + 999) / 1000;
  localparam int rc_divide         = 16;

  typedef enum logic [2:0] {
    st_idle, st_rc_delay, st_acquire, st_convert, st_finish
  } conv_state_t;

  // analog-side connection grouped as one carrier
  typedef struct packed {
    logic [3:0]  channel;
    logic        neg_ref_ext;
    logic        pos_ref_ext;
    logic [11:0] pin_analog;
    logic        sample;
    logic        calibrate;
    logic [9:0]  dac_code;
  } analog_ctrl_t;

endpackage

// file: sar_adc_control_unit.sv
// control unit of a 10-bit successive-approximation converter, 12 inputs
// assumes the comparator output comes from the analog block, rc tick from
// a free-running oscillator pin; both are synchronised here
//
// Behaviour
// RULE1 - convert selected input to 10-bit result
// RULE2 - calibrate_next set calibrates the next conversion
// RULE3 - channel_select codes 0..11 pick channel
// RULE4 - convert_go_busy reads busy while converter on
// RULE5 - converter_on enables or disables converter
// RULE6 - neg_ref_select picks channel 2 reference
// RULE7 - pos_ref_select picks channel 3 reference
// RULE8 - port_analog_config turns pins digital from eleven
// RULE9 - result_justify picks right or left placement
// RULE10 - acq_time_select programs acquisition bit periods
// RULE11 - conv_clock_select picks divider or rc
// RULE12 - rc clock adds one instruction-cycle delay
// RULE13 - sleep conversion only with rc clock
// RULE14 - successive approximation on sample-hold output
// RULE15 - completion loads result, clears busy, sets flag
// RULE16 - reset restores registers and aborts conversion
// RULE17 - power-on reset leaves result pair untouched
// RULE18 - programmed acquisition precedes automatic conversion start
// RULE19 - each conversion takes eleven bit periods
// RULE20 - resume sampling selected channel after conversion
// RULE21 - software waits two bit periods between conversions
// RULE22 - unused result bits read as zero
// RULE23 - write one to go starts; unused bits zero
`timescale 1ns/10ps
module sar_adc_control_unit
  import sar_adc_pkg::*;
(
  input  wire logic                       clock,
  input  wire logic                       reset,
  input  wire logic                       hsel,
  input  wire logic [31:0]                haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [31:0]                hwdata,
  input  wire logic                       hready,
  output logic      [31:0]                hrdata,
  output logic                            hreadyout,
  output logic                            hresp,
  input  wire logic                       sleep_mode,
  input  wire logic                       rc_osc_clock,
  input  wire logic                       comparator_high,
  output sar_adc_pkg::analog_ctrl_t       analog_ctrl,
  output logic                            conversion_done_flag
);
  import sar_adc_pkg::*;

  // ************************************************************
  // control registers
  // ************************************************************
  logic        calibrate_next;
  logic [3:0]  channel_select;
  logic        convert_go_busy;
  logic        converter_on;
  logic        neg_ref_select;
  logic        pos_ref_select;
  logic [3:0]  port_analog_config;
  logic        result_justify;
  logic [2:0]  acq_time_select;
  logic [2:0]  conv_clock_select;
  logic [9:0]  result_code;
  logic [9:0]  sar_code;
  conv_state_t state;
  logic [6:0]  prescale;
  logic [4:0]  period_count;
  logic [3:0]  bit_index;
  logic [4:0]  acq_periods;
  logic [5:0]  half_divide;
  logic        use_rc;
  logic        tick;
  logic        done_pulse;
  logic        clear_flag;
  logic        calibrate_pending;

  // ahb address phase capture
  logic        write_pending;
  logic        read_ok;
  logic [11:0] write_addr;
  logic        go_write;

  // synchronisers: first stage is read only by the second
  logic [1:0]  rc_sync;
  logic [1:0]  cmp_sync;
  logic [1:0]  sleep_sync;
  logic        rc_prev;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign read_ok   = hsel && hready && htrans[1] && !hwrite;

  // ************************************************************
  // bus slave: zero wait states, writes land in the data phase
  // ************************************************************
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      write_pending <= 1'b0;
      write_addr    <= 12'h000;
    end else begin
      write_pending <= hsel && hready && htrans[1] && hwrite;
      write_addr    <= haddr[11:0];
    end
  end

  assign go_write = write_pending && write_addr == main_control_addr
                    && hwdata[go_busy_bit] && converter_on && state == st_idle; // [RULE23]

  // two-flop synchronisers for rc tick, comparator and sleep; rc_prev holds last rc level
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rc_sync    <= 2'b00;
      cmp_sync   <= 2'b00;
      sleep_sync <= 2'b00;
      rc_prev    <= 1'b0;
    end else begin
      rc_sync    <= {rc_sync[0], rc_osc_clock};
      cmp_sync   <= {cmp_sync[0], comparator_high};
      sleep_sync <= {sleep_sync[0], sleep_mode};
      rc_prev    <= rc_sync[1];
    end
  end

  // ************************************************************
  // configuration registers
  // ************************************************************
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin // [RULE16]
      calibrate_next     <= control_reset[7];
      channel_select     <= control_reset[3:0];
      converter_on       <= control_reset[0];
      neg_ref_select     <= control_reset[0];
      pos_ref_select     <= control_reset[0];
      port_analog_config <= control_reset[3:0];
      result_justify     <= control_reset[0];
      acq_time_select    <= control_reset[2:0];
      conv_clock_select  <= control_reset[2:0];
    end else if (write_pending) begin
      case (write_addr)
        main_control_addr: begin
          calibrate_next <= hwdata[calibrate_bit];
          channel_select <= hwdata[chan_lsb +: 4];
          converter_on   <= hwdata[on_bit]; // [RULE5]
        end
        ref_port_addr: begin
          neg_ref_select     <= hwdata[neg_ref_bit];
          pos_ref_select     <= hwdata[pos_ref_bit];
          port_analog_config <= hwdata[3:0];
        end
        timing_format_addr: begin
          result_justify    <= hwdata[justify_bit];
          acq_time_select   <= hwdata[acq_lsb +: 3];
          conv_clock_select <= hwdata[2:0];
        end
        default: ;
      endcase
    end
  end

  // ************************************************************
  // bit period clock selection
  // ************************************************************
  assign use_rc = conv_clock_select[1:0] == 2'b11; // [RULE11]

  always_comb begin
    case (conv_clock_select)
      3'b000:  half_divide = 6'd1;
      3'b100:  half_divide = 6'd2;
      3'b001:  half_divide = 6'd4;
      3'b101:  half_divide = 6'd8;
      3'b010:  half_divide = 6'd16;
      3'b110:  half_divide = 6'd32;
      default: half_divide = 6'(rc_divide);
    endcase
  end

  // bit period tick; system divider stops in sleep, rc keeps running
  // divider counts half-rate reference cycles of two clocks each: the dac
  // register plus two comparator sync flops need four clocks per decision
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      prescale <= 7'd0;
      tick     <= 1'b0;
    end else if (use_rc) begin
      tick     <= rc_sync[1] && !rc_prev;
      prescale <= 7'd0;
    end else if (sleep_sync[1] || state == st_idle) begin // [RULE13]
      tick     <= 1'b0;
      prescale <= 7'd0;
    end else if ({1'b0, prescale} == {half_divide, 2'b00} - 8'd1) begin // [RULE11]
      tick     <= 1'b1;
      prescale <= 7'd0;
    end else begin
      tick     <= 1'b0;
      prescale <= prescale + 7'd1;
    end
  end

  // acquisition period lookup
  always_comb begin
    case (acq_time_select) // [RULE10]
      3'b000:  acq_periods = 5'd0;
      3'b001:  acq_periods = 5'd2;
      3'b010:  acq_periods = 5'd4;
      3'b011:  acq_periods = 5'd6;
      3'b100:  acq_periods = 5'd8;
      3'b101:  acq_periods = 5'd12;
      3'b110:  acq_periods = 5'd16;
      default: acq_periods = 5'd20;
    endcase
  end

  // ************************************************************
  // conversion sequencer
  // ************************************************************
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin // [RULE16]
      state             <= st_idle;
      period_count      <= 5'd0;
      bit_index         <= 4'd0;
      sar_code          <= 10'h000;
      convert_go_busy   <= 1'b0;
      done_pulse        <= 1'b0;
      calibrate_pending <= 1'b0;
    end else begin
      done_pulse <= 1'b0;
      if (!converter_on) begin // [RULE5]
        state           <= st_idle;
        convert_go_busy <= 1'b0;
      end else begin
        case (state)
          st_idle: if (go_write) begin
            convert_go_busy   <= 1'b1;
            calibrate_pending <= calibrate_next; // [RULE2]
            period_count      <= 5'd0;
            state <= use_rc ? st_rc_delay : st_acquire; // [RULE12]
          end
          st_rc_delay: begin
            period_count <= period_count + 5'd1;
            if (period_count == 5'(instr_cycle_clks - 1)) begin
              period_count <= 5'd0;
              state        <= st_acquire;
            end
          end
          st_acquire: begin // [RULE18]
            if (period_count >= acq_periods) begin
              period_count <= 5'd0;
              bit_index    <= 4'd0;
              sar_code     <= 10'h200;
              state        <= st_convert;
            end else if (tick) begin
              period_count <= period_count + 5'd1;
            end
          end
          st_convert: if (tick) begin // [RULE14] [RULE19]
            // first period settles, next ten resolve one bit each
            bit_index <= bit_index + 4'd1;
            if (bit_index != 4'd0) begin
              if (!cmp_sync[1]) begin
                sar_code[4'(result_bits) - bit_index] <= 1'b0;
              end
              if (bit_index != 4'(result_bits)) begin
                sar_code[4'(result_bits) - bit_index - 4'd1] <= 1'b1;
              end
            end
            if (bit_index == 4'(conv_periods - 1)) begin
              state <= st_finish;
            end
          end
          st_finish: begin // [RULE15] [RULE20]
            convert_go_busy   <= 1'b0;
            done_pulse        <= 1'b1;
            calibrate_pending <= 1'b0;
            state             <= st_idle;
          end
          default: state <= st_idle;
        endcase
      end
    end
  end

  // result pair: no reset so power-on leaves it unknown
  always_ff @(posedge clock) begin // [RULE17]
    if (done_pulse) begin
      result_code <= sar_code; // [RULE1]
    end
  end

  // done flag: set wins over software clear
  assign clear_flag = write_pending && write_addr == status_addr && hwdata[0];
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      conversion_done_flag <= 1'b0;
    end else if (done_pulse) begin
      conversion_done_flag <= 1'b1; // [RULE15]
    end else if (clear_flag) begin
      conversion_done_flag <= 1'b0;
    end
  end

  // ************************************************************
  // analog side controls
  // ************************************************************
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      analog_ctrl <= '0;
    end else begin
      analog_ctrl.channel     <= channel_select > last_channel ? 4'h0
                                 : channel_select; // [RULE3]
      analog_ctrl.neg_ref_ext <= neg_ref_select; // [RULE6]
      analog_ctrl.pos_ref_ext <= pos_ref_select; // [RULE7]
      for (int i = 0; i < 12; i++) begin // [RULE8]
        analog_ctrl.pin_analog[i] <= port_analog_config <= all_analog_top
                                     || 32'(port_analog_config) < 15 - i;
      end
      analog_ctrl.sample      <= converter_on && state != st_convert; // [RULE20]
      analog_ctrl.calibrate   <= calibrate_pending && state == st_convert;
      analog_ctrl.dac_code    <= sar_code;
    end
  end

  // ************************************************************
  // read mux, unimplemented bits read zero
  // ************************************************************
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      hrdata <= 32'h0000_0000;
    end else if (read_ok) begin
      case (haddr[11:0]) // [RULE23]
        main_control_addr: hrdata <= {24'h0, calibrate_next, 1'b0, channel_select,
                                      convert_go_busy && converter_on, converter_on}; // [RULE4]
        ref_port_addr: hrdata <= {26'h0, neg_ref_select, pos_ref_select,
                                  port_analog_config};
        timing_format_addr: hrdata <= {24'h0, result_justify, 1'b0, acq_time_select,
                                       conv_clock_select};
        result_low_addr: hrdata <= result_justify ? {24'h0, result_code[7:0]}
                                   : {24'h0, result_code[1:0], 6'h00}; // [RULE9] [RULE22]
        result_high_addr: hrdata <= result_justify ? {30'h0, result_code[9:8]}
                                    : {24'h0, result_code[9:2]}; // [RULE22]
        status_addr: hrdata <= {31'h0, conversion_done_flag};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// file: sar_adc_properties.sv
// assertions on the converter control unit ports
// assumes binding onto the top module, one clock domain
`timescale 1ns/10ps
module sar_adc_checker
  import sar_adc_pkg::*;
(
  input wire logic                      clock,
  input wire logic                      reset,
  input wire logic                      hsel,
  input wire logic [31:0]               haddr,
  input wire logic [1:0]                htrans,
  input wire logic                      hwrite,
  input wire logic [31:0]               hwdata,
  input wire logic                      hready,
  input wire logic                      hreadyout,
  input wire logic                      hresp,
  input wire sar_adc_pkg::analog_ctrl_t analog_ctrl,
  input wire logic                      conversion_done_flag
);
  // ****
  // helpers
  // ****
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  logic        ref_a, ref_s, st_a;
  logic [5:0]  ref_v;
  logic [15:0] low_n, run_n;
  // bus writes seen; closed-sampler run length kept so finish order does not matter
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      {ref_a, ref_s, st_a, ref_v, low_n, run_n} <= '0;
    end else begin
      ref_a <= hsel && hready && htrans[1] && hwrite && haddr[11:0] == ref_port_addr;
      st_a <= hsel && hready && htrans[1] && hwrite && haddr[11:0] == status_addr;
      ref_s <= ref_a;
      if (ref_a) ref_v <= hwdata[5:0];
      low_n <= analog_ctrl.sample ? 16'h0 : low_n + 16'(low_n != 16'hffff);
      if ($rose(analog_ctrl.sample)) run_n <= low_n;
    end
  end
  function automatic logic [11:0] pins_for(input logic [3:0] c);
    return (c < 4'h4) ? 12'hfff : 12'hfff >> (c - 4'h3);
  endfunction
  // ****
  // properties
  // ****
  a_ready_high: assert property (hreadyout)
    else $error("not ready");
  a_resp_okay: assert property (!hresp)
    else $error("resp not okay");
  a_chan_range: assert property (analog_ctrl.channel <= last_channel)
    else $error("channel out of range");
  a_pin_shape: assert property (
    ((analog_ctrl.pin_analog + 12'h1) & analog_ctrl.pin_analog) == 12'h0) else $error("pins");
  a_ref_follow: assert property (ref_s |-> ##[0:1] (
    {analog_ctrl.neg_ref_ext, analog_ctrl.pos_ref_ext} == ref_v[5:4] &&
    analog_ctrl.pin_analog == pins_for(ref_v[3:0]))) else $error("ref or pin config");
  a_conv_len: assert property ($rose(conversion_done_flag) |->
    (run_n >= 16'd22 || low_n >= 16'd22)) else $error("conversion too short");
  a_resume_sample: assert property (
    $rose(conversion_done_flag) |-> ##[0:2] analog_ctrl.sample) else $error("no resample");
  a_flag_sticky: assert property (
    conversion_done_flag && !st_a |=> conversion_done_flag) else $error("flag dropped");
  c_done: cover property ($rose(conversion_done_flag));
  c_ref: cover property (ref_s);
  c_conv: cover property ($fell(analog_ctrl.sample));
endmodule
bind sar_adc_control_unit sar_adc_checker chk_u (.clock, .reset, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hreadyout, .hresp, .analog_ctrl, .conversion_done_flag);

// file: analog_side_model.sv
// analog side: per-channel sources, hold stage, comparator, rc oscillator
// assumes source levels derived from a base value the bench drives
`timescale 1ns/10ps
module analog_side_model
  import sar_adc_pkg::*;
(
  input wire sar_adc_pkg::analog_ctrl_t analog_ctrl,
  input wire logic [9:0]                base,
  output logic                          comparator_high,
  output logic                          rc_osc_clock
);
  logic [9:0] held;
  // hold stage tracks the selected source only while sampling
  always_latch begin
    if (analog_ctrl.sample) held <= base + 10'(analog_ctrl.channel * 37);
  end
  // input half a step above its code, so ties resolve upward
  assign comparator_high = {held, 1'b1} > {analog_ctrl.dac_code, 1'b0};
  // rc oscillator runs free, unrelated to the system clock
  initial rc_osc_clock = 1'b0;
  always #20 rc_osc_clock = ~rc_osc_clock;
endmodule

// file: tb.sv
// self-checking bench: ahb-lite tasks, analog model, random conversions
// assumes a zero-wait slave with the analog model beside it
`timescale 1ns/10ps
module tb;
  import sar_adc_pkg::*;
  logic         clock = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0, sleep_mode = 1'b0;
  logic [1:0]   htrans = 2'h0;
  logic [31:0]  haddr = '0, hwdata = '0, hrdata, rd, seed = 32'd49135;
  logic [9:0]   base = 10'h0;
  logic         hreadyout, rc_osc_clock, comparator_high, conversion_done_flag;
  analog_ctrl_t analog_ctrl;
  int           bad_count = 0, samples_checked = 0, cycles = 0, t0;
  int           acq_tab[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
  logic [11:0]  ad[5] = '{main_control_addr, ref_port_addr, timing_format_addr,
                          status_addr, 12'h020};
  // ****
  // clock, design, model
  // ****
  always #2.5 clock = ~clock;
  sar_adc_control_unit dut_u (.clock, .reset, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp(), .sleep_mode,
    .rc_osc_clock, .comparator_high, .analog_ctrl, .conversion_done_flag);
  analog_side_model model_u (.analog_ctrl, .base, .comparator_high, .rc_osc_clock);
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // a hang counts as a mismatch
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // single transfer: hold address phase until ready, then data phase until ready
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic wflag();
    repeat (6000) if (conversion_done_flag !== 1'b1) @(posedge clock);
  endtask
  task automatic chk_reset();
    foreach (ad[k]) begin
      bus(1'b0, ad[k], '0);
      chk("reset_val", rd, '0);
    end
  endtask
  // one conversion; elapsed cycles must land in lo..hi
  task automatic conv(input logic [3:0] ch, input logic [7:0] tm, input int lo, input int hi);
    logic [15:0] e;
    e = tm[7] ? {6'h0, base + 10'(ch * 37)} : {base + 10'(ch * 37), 6'h0};
    bus(1'b1, timing_format_addr, {24'h0, tm});
    bus(1'b1, main_control_addr, {26'h0, ch, 2'h1});
    bus(1'b1, main_control_addr, {26'h0, ch, 2'h3});
    t0 = cycles;
    bus(1'b0, main_control_addr, '0);
    chk("busy", rd[1], 1'b1);
    chk("chan", analog_ctrl.channel, ch);
    wflag();
    chk("time", cycles - t0 >= lo && cycles - t0 <= hi, 1'b1);
    chk("flag", conversion_done_flag, 1'b1);
    bus(1'b0, main_control_addr, '0);
    chk("idle", rd[1:0], 2'h1);
    bus(1'b0, result_high_addr, '0);
    chk("res_hi", rd, e[15:8]);
    bus(1'b0, result_low_addr, '0);
    chk("res_lo", rd, e[7:0]);
    bus(1'b1, status_addr, 32'h1);
    bus(1'b0, status_addr, '0);
    chk("flag_clr", rd, '0);
    repeat (20) @(posedge clock); // rest before next acquisition
  endtask
  // ****
  // scenarios
  // ****
  initial begin
    logic [31:0] v;
    logic [2:0]  cs, aq;
    int          bp;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    chk_reset();
    bus(1'b1, main_control_addr, 32'h2);
    bus(1'b0, main_control_addr, '0);
    chk("go_off", rd, '0);
    bus(1'b1, 12'h020, 32'hff);
    bus(1'b0, 12'h020, '0);
    chk("unmapped", rd, '0);
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, ad[k], 32'hff);
      bus(1'b0, ad[k], '0);
      chk("rw_mask", rd, k == 0 ? 32'hbd : k == 1 ? 32'h3f : 32'hbf);
    end
    chk("unused_chan", analog_ctrl.channel, '0);
    for (int c = 0; c < 16; c++) begin
      v = (rnd() & 32'h30) | c;
      bus(1'b1, ref_port_addr, v);
      repeat (2) @(posedge clock);
      chk("pins", analog_ctrl.pin_analog, c < 4 ? 12'hfff : 12'hfff >> (c - 3));
      chk("refs", {analog_ctrl.neg_ref_ext, analog_ctrl.pos_ref_ext}, v[5:4]);
    end
    bus(1'b1, main_control_addr, 32'h1);
    for (int i = 0; i < 6; i++) begin
      v = rnd();
      aq = i == 0 ? 3'h7 : i == 1 ? 3'h0 : v[6:4];
      cs = v[9:8] == 2'h0 ? 3'h0 : v[9:8] == 2'h1 ? 3'h4 : 3'h1;
      bp = cs == 3'h0 ? 4 : cs == 3'h4 ? 8 : 16;
      base <= v[19:10];
      @(posedge clock);
      conv(i == 0 ? 4'hb : 4'(v[23:20] % 12), {v[0], 1'b0, aq, cs},
           (acq_tab[aq] + 10) * bp, (acq_tab[aq] + 12) * bp + 8);
    end
    sleep_mode <= 1'b1;
    bus(1'b1, timing_format_addr, 32'h80);
    bus(1'b1, main_control_addr, 32'h81);
    bus(1'b1, main_control_addr, 32'h83);
    repeat (200) @(posedge clock);
    chk("sleep_hold", conversion_done_flag, 1'b0);
    chk("calibrate", analog_ctrl.calibrate, 1'b1);
    sleep_mode <= 1'b0;
    wflag();
    chk("wake_done", conversion_done_flag, 1'b1);
    bus(1'b1, status_addr, 32'h1);
    sleep_mode <= 1'b1;
    conv(4'h5, 8'h83, 84, 600);
    conv(4'h2, 8'h07, 84, 600);
    sleep_mode <= 1'b0;
    bus(1'b1, timing_format_addr, 32'h38);
    bus(1'b1, main_control_addr, 32'h7);
    repeat (10) @(posedge clock);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    repeat (100) @(posedge clock);
    chk("abort", conversion_done_flag, 1'b0);
    chk_reset();
    end_sim();
  end
endmodule
